// ==== hdl/sfp_cfg.svh ====
// Purpose: constants of the serial protected memory slave
// Assumes: one system clock at 20 MHz samples every link pin
// Notes: offsets, opcodes, field positions and sizes only
//
// Summary of operation
// - status bits 0, 4-6 read zero, unwritable
// - bit 1 shows write latch, zero after reset
// - status write data never sets latch bit
// - block guard bits sit at bits 3, 2
// - guard code picks protected top region
// - pin enable plus low pin refuses status write
// - array write needs latch, unguarded address
// - protect pin never blocks array writes
// - status read shifts status byte, msb first
// - status write updates bits 7,3,2; clears latch
// - two address bytes, top three bits ignored
// - burst address increments, wraps to zero
// - each byte stored at its eighth bit
// - guarded address stops burst, discards rest
// - select rising ends write command
// - read drives data, ignores serial input
// - select rising ends read, output released
// - hold sampled at clock low pauses, resumes
// - latch cleared at select rise after writes
// - first byte is opcode, six codes
// - unknown opcode ignored until next select
// - clock level at select picks mode 0/3
`ifndef SFP_CFG_SVH
`define SFP_CFG_SVH

`define SFP_ADDR_W 13
`define SFP_DATA_W 8
`define SFP_FIFO_DEPTH 32

`define SFP_OP_LATCH_SET 8'h06
`define SFP_OP_LATCH_CLEAR 8'h04
`define SFP_OP_STATUS_READ 8'h05
`define SFP_OP_STATUS_WRITE 8'h01
`define SFP_OP_MEM_READ 8'h03
`define SFP_OP_MEM_WRITE 8'h02

`define SFP_STAT_RESET 8'h00
`define SFP_BIT_PIN_EN 7
`define SFP_BIT_GUARD_HI 3
`define SFP_BIT_GUARD_LO 2
`define SFP_BIT_LATCH 1

`define SFP_GUARD_QUARTER 13'h1800
`define SFP_GUARD_HALF 13'h1000

`endif

// ==== hdl/sfp_pkg.sv ====
// Purpose: types shared by the memory slave modules
// Assumes: constants come from the cfg header
// Notes: core state is one packed struct
`include "sfp_cfg.svh"

package sfp_pkg;

    typedef enum logic [3:0] {
        ST_IDLE     = 4'b0000,
        ST_OPCODE   = 4'b0001,
        ST_ADDR_HI  = 4'b0010,
        ST_ADDR_LO  = 4'b0011,
        ST_WDATA    = 4'b0100,
        ST_RDATA    = 4'b0101,
        ST_STAT_W   = 4'b0110,
        ST_STAT_R   = 4'b0111,
        ST_DONE     = 4'b1000,
        ST_IGNORE   = 4'b1001
    } sfp_state_t;

    typedef struct packed {
        logic [`SFP_ADDR_W-1:0] addr;
        logic [`SFP_DATA_W-1:0] data;
    } sfp_wr_entry_t;

    typedef struct packed {
        logic sck_m;
        logic sck_s;
        logic sck_p;
        logic cs_m;
        logic cs_s;
        logic cs_p;
        logic si_m;
        logic si_s;
        logic hold_m;
        logic hold_s;
        logic wp_m;
        logic wp_s;
        sfp_state_t state;
        logic [2:0] cnt;
        logic [7:0] shift;
        logic [7:0] tx;
        logic [`SFP_ADDR_W-1:0] addr;
        logic is_read;
        logic clear_on_rise;
        logic burst_stop;
        logic mode3;
        logic hold_act;
        logic rd_req;
        logic rd_wait;
        logic push_valid;
        sfp_wr_entry_t push_data;
        logic write_latch_flag;
        logic pin_en;
        logic [1:0] guard;
        logic drive;
        logic so;
        logic so_oe;
    } sfp_core_state_t;

endpackage

// ==== hdl/sfp_if.sv ====
// Purpose: carriers between the core, its fifo and its array
// Assumes: single clock domain on both sides
// Notes: array read data appear one cycle after a read
`include "sfp_cfg.svh"
interface sfp_mem_if;
    logic en;
    logic we;
    logic [`SFP_ADDR_W-1:0] addr;
    logic [`SFP_DATA_W-1:0] wdata;
    logic [`SFP_DATA_W-1:0] rdata;
    modport user (output en, output we, output addr, output wdata, input rdata);
    modport store (input en, input we, input addr, input wdata, output rdata);
endinterface

interface sfp_stream_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, input ready, output data);
    modport snk (input valid, output ready, input data);
endinterface

// ==== hdl/sfp_store.sv ====
// Purpose: byte array and write fifo of the memory slave
// Assumes: one port on the array, read data registered
// Notes: array contents are not reset, like real cells
`include "sfp_cfg.svh"
module sfp_ram
    import sfp_pkg::*;
#(
    parameter int AW = `SFP_ADDR_W,
    parameter int DW = `SFP_DATA_W
)
(
    // clock
    input wire logic clock,
    // array port
    sfp_mem_if.store port
);
    logic [DW-1:0] cells [0:(1<<AW)-1];
    logic [DW-1:0] rdata_q;

    always_ff @(posedge clock)
    begin
        if (port.en && port.we)
        begin
            cells[port.addr] <= port.wdata;
        end
        if (port.en && !port.we)
        begin
            rdata_q <= cells[port.addr];
        end
    end

    assign port.rdata = rdata_q;
endmodule

module sfp_fifo
    import sfp_pkg::*;
#(
    parameter int WIDTH = 21,
    parameter int DEPTH = `SFP_FIFO_DEPTH
)
(
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // filling side
    sfp_stream_if.snk in_s,
    // draining side
    sfp_stream_if.src out_s
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] slots [0:DEPTH-1];
    logic [PW:0] wr_q;
    logic [PW:0] rd_q;
    logic full;
    logic empty;

    assign empty = (wr_q == rd_q);
    assign full = (wr_q[PW] != rd_q[PW]) && (wr_q[PW-1:0] == rd_q[PW-1:0]);
    assign in_s.ready = !full;
    assign out_s.valid = !empty;
    assign out_s.data = slots[rd_q[PW-1:0]];

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            if (in_s.valid && !full)
            begin
                slots[wr_q[PW-1:0]] <= in_s.data;
                wr_q <= wr_q + 1'b1;
            end
            if (out_s.ready && !empty)
            begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule

// ==== hdl/sfp_core.sv ====
// Purpose: command logic of a serial memory slave with write guards
// Assumes: link pins are asynchronous, clock at least 8x the link clock
// Notes: received bytes pass a fifo on their way into the array
`include "sfp_cfg.svh"
module sfp_core
    import sfp_pkg::*;
#(
    parameter int FIFO_DEPTH = `SFP_FIFO_DEPTH
)
(
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // link pins from the master
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    // serial output pin
    output logic so,
    output logic so_oe,
    // observed state
    output logic mode3
);
    localparam int EW = $bits(sfp_wr_entry_t);

    sfp_core_state_t q;
    sfp_core_state_t d;

    sfp_mem_if mem ();
    sfp_stream_if #(.W(EW)) push_s ();
    sfp_stream_if #(.W(EW)) pop_s ();

    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    logic cs_fall;
    logic [7:0] rx_byte;
    logic [7:0] status;
    sfp_wr_entry_t pop_entry;

    function automatic logic guarded(input logic [1:0] g,
                                     input logic [`SFP_ADDR_W-1:0] a);
        logic hit;
        hit = 1'b0;
        unique case (g)
            2'b00: hit = 1'b0;
            2'b01: hit = (a >= `SFP_GUARD_QUARTER);
            2'b10: hit = (a >= `SFP_GUARD_HALF);
            2'b11: hit = 1'b1;
        endcase
        return hit;
    endfunction

    assign sck_rise = q.sck_s && !q.sck_p;
    assign sck_fall = !q.sck_s && q.sck_p;
    assign cs_fall = !q.cs_s && q.cs_p;
    assign cs_rise = q.cs_s && !q.cs_p;
    assign rx_byte = {q.shift[6:0], q.si_s};

    always_comb
    begin
        status = `SFP_STAT_RESET;
        status[`SFP_BIT_PIN_EN] = q.pin_en;
        status[`SFP_BIT_GUARD_HI] = q.guard[1];
        status[`SFP_BIT_GUARD_LO] = q.guard[0];
        status[`SFP_BIT_LATCH] = q.write_latch_flag;
    end

    // one array port: a pending read wins, the fifo drain waits
    assign pop_entry = sfp_wr_entry_t'(pop_s.data);
    assign pop_s.ready = !q.rd_req;
    assign mem.en = q.rd_req || pop_s.valid;
    assign mem.we = !q.rd_req;
    assign mem.addr = q.rd_req ? q.addr : pop_entry.addr;
    assign mem.wdata = pop_entry.data;

    assign push_s.valid = q.push_valid;
    assign push_s.data = q.push_data;

    sfp_fifo #(
        .WIDTH(EW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .resetn(resetn),
        .in_s(push_s),
        .out_s(pop_s)
    );

    sfp_ram u_ram (
        .clock(clock),
        .port(mem)
    );

    always_comb
    begin
        d = q;
        d.push_valid = 1'b0;
        d.rd_req = 1'b0;
        d.rd_wait = q.rd_req;

        // two flops on every pin before use
        d.sck_m = sck;
        d.sck_s = q.sck_m;
        d.sck_p = q.sck_s;
        d.cs_m = cs_n;
        d.cs_s = q.cs_m;
        d.cs_p = q.cs_s;
        d.si_m = si;
        d.si_s = q.si_m;
        d.hold_m = hold_n;
        d.hold_s = q.hold_m;
        d.wp_m = wp_n;
        d.wp_s = q.wp_m;

        // hold follows its pin only while the clock is low
        if (!q.sck_s)
        begin
            d.hold_act = !q.hold_s;
        end

        // registered array data become the next byte to shift out
        if (q.rd_wait)
        begin
            d.tx = mem.rdata;
        end

        if (cs_rise)
        begin
            if (q.clear_on_rise)
            begin
                d.write_latch_flag = 1'b0;
            end
            d.state = ST_IDLE;
            d.drive = 1'b0;
        end
        else if (cs_fall)
        begin
            d.state = ST_OPCODE;
            d.cnt = 3'h0;
            d.mode3 = q.sck_s;
            d.clear_on_rise = 1'b0;
            d.burst_stop = 1'b0;
            d.is_read = 1'b0;
            d.drive = 1'b0;
        end
        else if (!q.hold_act && q.state != ST_IDLE && q.state != ST_IGNORE)
        begin
            if (sck_rise)
            begin
                d.shift = rx_byte;
                d.cnt = q.cnt + 3'h1;
                if (q.cnt == 3'h7)
                begin
                    unique case (q.state)
                        ST_OPCODE:
                        begin
                            unique case (rx_byte)
                                `SFP_OP_LATCH_SET:
                                begin
                                    // only this opcode sets the latch
                                    d.write_latch_flag = 1'b1;
                                    d.state = ST_DONE;
                                end
                                `SFP_OP_LATCH_CLEAR:
                                begin
                                    d.clear_on_rise = 1'b1;
                                    d.state = ST_DONE;
                                end
                                `SFP_OP_STATUS_READ:
                                begin
                                    d.tx = status;
                                    d.state = ST_STAT_R;
                                end
                                `SFP_OP_STATUS_WRITE:
                                begin
                                    d.clear_on_rise = 1'b1;
                                    d.state = ST_STAT_W;
                                end
                                `SFP_OP_MEM_READ:
                                begin
                                    d.is_read = 1'b1;
                                    d.state = ST_ADDR_HI;
                                end
                                `SFP_OP_MEM_WRITE:
                                begin
                                    d.clear_on_rise = 1'b1;
                                    d.state = ST_ADDR_HI;
                                end
                                default:
                                begin
                                    d.state = ST_IGNORE;
                                end
                            endcase
                        end
                        ST_ADDR_HI:
                        begin
                            d.addr = {rx_byte[4:0], q.addr[7:0]};
                            d.state = ST_ADDR_LO;
                        end
                        ST_ADDR_LO:
                        begin
                            d.addr = {q.addr[12:8], rx_byte};
                            if (q.is_read)
                            begin
                                d.rd_req = 1'b1;
                                d.state = ST_RDATA;
                            end
                            else
                            begin
                                d.state = ST_WDATA;
                            end
                        end
                        ST_WDATA:
                        begin
                            // latch and guard only, pin unused
                            if (q.write_latch_flag && !q.burst_stop)
                            begin
                                if (guarded(q.guard, q.addr))
                                begin
                                    d.burst_stop = 1'b1;
                                end
                                else if (push_s.ready)
                                begin
                                    d.push_valid = 1'b1;
                                    d.push_data = '{addr: q.addr, data: rx_byte};
                                    d.addr = q.addr + 13'h0001;
                                end
                            end
                        end
                        ST_RDATA:
                        begin
                            d.addr = q.addr + 13'h0001;
                            d.rd_req = 1'b1;
                        end
                        ST_STAT_W:
                        begin
                            // pin guard and latch gate the update
                            if (q.write_latch_flag && !(q.pin_en && !q.wp_s))
                            begin
                                // only bits 7, 3, 2 taken
                                d.pin_en = rx_byte[`SFP_BIT_PIN_EN];
                                d.guard = {rx_byte[`SFP_BIT_GUARD_HI],
                                           rx_byte[`SFP_BIT_GUARD_LO]};
                            end
                            d.state = ST_DONE;
                        end
                        ST_STAT_R:
                        begin
                            d.tx = status;
                        end
                        ST_DONE:
                        begin
                            d.state = ST_DONE;
                        end
                        default:
                        begin
                            d.state = ST_IGNORE;
                        end
                    endcase
                end
            end
            else if (sck_fall && (q.state == ST_RDATA || q.state == ST_STAT_R))
            begin
                d.so = q.tx[7];
                d.tx = {q.tx[6:0], 1'b0};
                d.drive = 1'b1;
            end
        end

        // output released while deselected or held
        d.so_oe = d.drive && !d.hold_act && !q.cs_s;
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            // latch clear at reset; guard bits at factory value
            q <= '{
                sck_m: 1'b0, sck_s: 1'b0, sck_p: 1'b0,
                cs_m: 1'b1, cs_s: 1'b1, cs_p: 1'b1,
                si_m: 1'b0, si_s: 1'b0,
                hold_m: 1'b1, hold_s: 1'b1,
                wp_m: 1'b1, wp_s: 1'b1,
                state: ST_IDLE,
                cnt: 3'h0,
                shift: 8'h00,
                tx: 8'h00,
                addr: 13'h0000,
                is_read: 1'b0,
                clear_on_rise: 1'b0,
                burst_stop: 1'b0,
                mode3: 1'b0,
                hold_act: 1'b0,
                rd_req: 1'b0,
                rd_wait: 1'b0,
                push_valid: 1'b0,
                push_data: '0,
                write_latch_flag: 1'b0,
                pin_en: 1'b0,
                guard: 2'b00,
                drive: 1'b0,
                so: 1'b0,
                so_oe: 1'b0
            };
        end
        else
        begin
            q <= d;
        end
    end

    assign so = q.so;
    assign so_oe = q.so_oe;
    assign mode3 = q.mode3;
endmodule

// ==== verification/sfp_core_chk.sv ====
// Purpose: port checks of the serial protected memory slave
// Assumes: each link clock level lasts at least 4 system clocks
// Notes: sees only the top module pins
module sfp_core_chk (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // link pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    // outputs
    input wire logic so,
    input wire logic so_oe,
    input wire logic mode3
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    oe_release_a: assert property ($rose(cs_n) |-> ##[1:4] !so_oe)
        else $error("output enable kept after deselect");
    oe_idle_a: assert property (cs_n [*5] |-> !so_oe)
        else $error("output driven while deselected");
    oe_hold_a: assert property ((!hold_n && !cs_n) [*5] |-> !so_oe)
        else $error("output driven during hold");
    oe_start_a: assert property ($rose(so_oe) |-> !cs_n && !$past(cs_n, 8))
        else $error("output enabled too early");
    so_edge_a: assert property (so_oe && $past(so_oe) && $changed(so) |-> !sck)
        else $error("output bit moved with link clock high");
    mode_hi_a: assert property ($fell(cs_n) && sck |-> ##[2:5] mode3)
        else $error("mode 3 not recorded");
    mode_lo_a: assert property ($fell(cs_n) && !sck |-> ##[2:5] !mode3)
        else $error("mode 0 not recorded");
    mode_keep_a: assert property (!cs_n [*6] |=> $stable(mode3))
        else $error("mode changed inside select");
    reset_out_a: assert property (disable iff (1'b0) !resetn |=> !so_oe && !mode3)
        else $error("outputs not cleared by reset");

    cover property ($rose(so_oe));
    cover property ($rose(mode3));
    cover property (!hold_n && !cs_n && sck);
endmodule

bind sfp_core sfp_core_chk sfp_core_chk_i (
    .clock(clock),
    .resetn(resetn),
    .cs_n(cs_n),
    .sck(sck),
    .si(si),
    .hold_n(hold_n),
    .wp_n(wp_n),
    .so(so),
    .so_oe(so_oe),
    .mode3(mode3)
);

// ==== verification/sfp_master.sv ====
// Purpose: link master model facing the memory slave
// Assumes: link clock 400 ns, pins moved on system clock falls
// Notes: a released output line reads as the inverse of its last bit
module sfp_master (
    // system clock
    input wire logic clock,
    // link pins
    output logic cs_n,
    output logic sck,
    output logic si,
    output logic hold_n,
    output logic wp_n,
    input wire logic so,
    input wire logic so_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    int hold_at = -1;
    logic miso;
    // simulator would settle a floating line at will
    assign miso = so_oe ? so : ~so;

    initial
    begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
        wp_n = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clock);
    endtask

    // pin levels between commands, bit index of the hold pause
    task automatic set_pins(input logic wp, input int hold);
        wp_n = wp;
        hold_at = hold;
    endtask

    task automatic sel(input logic m3);
        sck = m3;
        wait_clk(4);
        cs_n = 1'b0;
        wait_clk(4);
    endtask

    task automatic desel(input logic m3);
        sck = m3;
        wait_clk(4);
        cs_n = 1'b1;
        wait_clk(8);
    endtask

    // msb first, hold moves only with clock low
    task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            sck = 1'b0;
            si = tx[i];
            wait_clk(4);
            if (i == hold_at)
            begin
                hold_n = 1'b0;
                wait_clk(4);
                repeat (2)
                begin
                    sck = 1'b1;
                    si = ~si;
                    wait_clk(4);
                    sck = 1'b0;
                    wait_clk(4);
                end
                si = tx[i];
                hold_n = 1'b1;
                wait_clk(4);
            end
            rx[i] = miso;
            sck = 1'b1;
            wait_clk(4);
        end
    endtask
endmodule

// ==== verification/sfp_core_tb.sv ====
// Purpose: self-checking bench of the serial protected memory slave
// Assumes: reset stands for first power-on, status starts at zero
// Notes: array contents are unknown until written
`include "sfp_cfg.svh"
module sfp_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic cs_n, sck, si, hold_n, wp_n, so, so_oe, mode3;
    logic oe_seen;
    logic [7:0] rx;
    logic [15:0] q;
    int failures = 0;
    int tests_run = 0;

    always #25 clock = ~clock;
    always @(posedge clock) if (so_oe === 1'b1) oe_seen <= 1'b1;

    sfp_core sfp_core_i (.clock(clock), .resetn(resetn), .cs_n(cs_n), .sck(sck), .si(si),
        .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe), .mode3(mode3));
    sfp_master sfp_master_i (.clock(clock), .cs_n(cs_n), .sck(sck), .si(si),
        .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe));

    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic pair(input logic m3, input logic [7:0] op, input logic [7:0] v);
        sfp_master_i.sel(m3);
        sfp_master_i.xb(op, rx);
        sfp_master_i.xb(v, rx);
        sfp_master_i.desel(m3);
        q = {8'h00, rx};
    endtask

    task automatic stat(input logic m3);
        pair(m3, `SFP_OP_STATUS_READ, 8'hFF);
    endtask

    task automatic wr(input logic [7:0] v);
        pair(1'b0, `SFP_OP_STATUS_WRITE, v);
    endtask

    // latch set or clear in its own select
    task automatic cmd(input logic [7:0] op);
        sfp_master_i.sel(1'b0);
        sfp_master_i.xb(op, rx);
        sfp_master_i.desel(1'b0);
    endtask

    task automatic mem(input logic [7:0] op, input logic [15:0] a, input logic [15:0] d);
        sfp_master_i.sel(1'b0);
        sfp_master_i.xb(op, rx);
        sfp_master_i.xb(a[15:8], rx);
        sfp_master_i.xb(a[7:0], rx);
        sfp_master_i.xb(d[15:8], q[15:8]);
        sfp_master_i.xb(d[7:0], q[7:0]);
        sfp_master_i.desel(1'b0);
    endtask

    task automatic t_latch();
        stat(1'b0);
        check("status after reset", q, 16'h0000);
        cmd(`SFP_OP_LATCH_SET);
        stat(1'b0);
        check("latch set", q, 16'h0002);
        cmd(`SFP_OP_LATCH_CLEAR);
        stat(1'b0);
        check("latch clear", q, 16'h0000);
        $display("test latch done");
    endtask

    task automatic t_wrap();
        cmd(`SFP_OP_LATCH_SET);
        mem(`SFP_OP_MEM_WRITE, 16'hFFFF, 16'h1122);
        mem(`SFP_OP_MEM_WRITE, 16'h0000, 16'h5566);
        mem(`SFP_OP_MEM_READ, 16'hBFFF, 16'hFFFF);
        check("wrap and unlatched write", q, 16'h1122);
        $display("test wrap done");
    endtask

    task automatic t_hold();
        cmd(`SFP_OP_LATCH_SET);
        // pause kept through the read too, so output release is exercised
        sfp_master_i.set_pins(1'b1, 3);
        mem(`SFP_OP_MEM_WRITE, 16'h0100, 16'hA55A);
        mem(`SFP_OP_MEM_READ, 16'h0100, 16'h0000);
        check("write across hold", q, 16'hA55A);
        $display("test hold done");
    endtask

    task automatic t_status();
        cmd(`SFP_OP_LATCH_SET);
        wr(8'hFF);
        stat(1'b0);
        check("status write", q, 16'h008C);
        sfp_master_i.set_pins(1'b0, -1);
        cmd(`SFP_OP_LATCH_SET);
        wr(8'h00);
        sfp_master_i.set_pins(1'b1, -1);
        stat(1'b0);
        check("pin refused write", q, 16'h008C);
        wr(8'h00);
        stat(1'b0);
        check("unlatched status write", q, 16'h008C);
        $display("test status done");
    endtask

    task automatic t_guard();
        logic [7:0] v;
        logic [7:0] lo;
        logic [7:0] hi;
        for (int g = 0; g < 4; g++)
        begin
            v = 8'h40 + g[7:0];
            cmd(`SFP_OP_LATCH_SET);
            wr({1'b1, 3'b000, g[1:0], 2'b00});
            stat(1'b0);
            check("guard code", q, {8'h00, 1'b1, 3'b000, g[1:0], 2'b00});
            sfp_master_i.set_pins(1'b0, -1);
            cmd(`SFP_OP_LATCH_SET);
            mem(`SFP_OP_MEM_WRITE, 16'h17FF, {v, v});
            sfp_master_i.set_pins(1'b1, -1);
            if (g < 2) lo = v;
            if (g == 0) hi = v;
            mem(`SFP_OP_MEM_READ, 16'h17FF, 16'h0000);
            check("guarded burst", q, {lo, hi});
        end
        $display("test guard done");
    endtask

    task automatic t_badop();
        oe_seen = 1'b0;
        sfp_master_i.sel(1'b0);
        sfp_master_i.xb(8'hFF, rx);
        sfp_master_i.xb(`SFP_OP_STATUS_READ, rx);
        sfp_master_i.desel(1'b0);
        check("unknown opcode output", {15'h0000, oe_seen}, 16'h0000);
        $display("test opcode done");
    endtask

    task automatic t_mode3();
        stat(1'b1);
        check("status in mode 3", q, 16'h008C);
        check("mode flag", {15'h0000, mode3}, 16'h0001);
        stat(1'b0);
        check("mode flag back", {15'h0000, mode3}, 16'h0000);
        $display("test mode done");
    endtask

    initial
    begin
        oe_seen = 1'b0;
        repeat (10) @(negedge clock);
        resetn = 1'b1;
        repeat (4) @(negedge clock);
        t_latch();
        t_wrap();
        t_hold();
        t_status();
        t_guard();
        t_badop();
        t_mode3();
        stop_test();
    end

    // a hung run counts as a mismatch
    initial
    begin
        repeat (100000) @(posedge clock);
        failures++;
        stop_test();
    end
endmodule
